/* File: dv/arith_checker.sv */
// Concurrent checks on the register bus and flags of the coprocessor.
// Assumes it sits beside the bus interface, one clock and one reset.
`default_nettype none
module arith_checker
	import arith_pkg::*;
(
	input wire logic       pclk,                // Clock
	input wire logic       presetn,             // Reset, active low
	input wire logic [7:0] sfr_addr,            // Register address
	input wire logic       sfr_wr,              // Write strobe
	input wire logic       sfr_rd,              // Read strobe
	input wire logic [7:0] sfr_wdata,           // Write data
	input wire logic [7:0] sfr_rdata,           // Read data
	input wire logic       calc_busy,           // Executing
	input wire logic       calc_done_flag,      // Finish flag
	input wire logic       calc_error_flag,     // Error flag
	input wire logic       arith_overflow_flag  // Overflow flag
);
	logic [4:0] run_len;

	// Decoded accesses that touch the error logic
	wire ctl_rd = sfr_rd && sfr_addr == ADDR_CTRL;
	wire md_wr  = sfr_wr && (sfr_addr inside {ADDR_CTRL, ADDR_OP0,
		ADDR_OP1, ADDR_OP2, ADDR_OP3, ADDR_OP4, ADDR_OP5});

	// Length of the current run, restarted by any write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_len <= 5'h00;
		else if (!calc_busy || sfr_wr)
			run_len <= 5'h00;
		else
			run_len <= run_len + 5'h01;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_busy_no_done: assert property (
		calc_busy |-> !calc_done_flag)
		else $error("finish flag high while busy");
	a_done_at_end: assert property (
		$rose(calc_done_flag) |-> $fell(calc_busy))
		else $error("finish flag rose without completion");
	a_start_by_write: assert property (
		$rose(calc_busy) |-> $past(sfr_wr))
		else $error("run started without a write");
	a_run_bounded: assert property (run_len <= 5'd19)
		else $error("run longer than 19 cycles");
	a_rdata_held: assert property (
		!$past(sfr_rd) |-> $stable(sfr_rdata))
		else $error("read data changed without a read");
	a_err_on_write: assert property (
		calc_busy && md_wr |=> calc_error_flag)
		else $error("write during run left error clear");
	a_err_sticky: assert property (
		calc_error_flag && !ctl_rd |=> calc_error_flag)
		else $error("error flag cleared without control read");
	a_err_cleared: assert property (
		ctl_rd && !calc_busy |=> !calc_error_flag)
		else $error("control read left error set");
	a_err_caused: assert property (
		!calc_error_flag && !(calc_busy && (sfr_wr || sfr_rd))
		|=> !calc_error_flag)
		else $error("error flag set without cause");
	a_ovf_at_end: assert property (
		$changed(arith_overflow_flag) |-> $fell(calc_busy))
		else $error("overflow changed outside an operation");
endmodule : arith_checker
`default_nettype wire

/* File: dv/mul_div_shift_unit_tb.sv */
// Bench: APB host drives the coprocessor over the register bus.
// Assumes both ends share pclk and presetn; results checked by a monitor.
`default_nettype none
module mul_div_shift_unit_tb
	import arith_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        busy, done, err, ovf, rd_seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, c, d;
	logic [8:0]  exp_rd [$];
	logic [8:0]  st_x;
	int          exp_len [$];
	int          errors, checked, seed, run_len, i;
	logic [7:0]  regs [8] = '{ADDR_MODE, ADDR_CTRL, ADDR_OP0, ADDR_OP1,
		ADDR_OP2, ADDR_OP3, ADDR_OP4, ADDR_OP5};
	op_t         ops [4] = '{OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT};

	sfr_if sfr_if_i ();
	arith_host arith_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(sfr_if_i));
	arith_coprocessor arith_coprocessor_i (.pclk(pclk), .presetn(presetn),
		.bus(sfr_if_i), .calc_busy(busy), .calc_done_flag(done),
		.calc_error_flag(err), .arith_overflow_flag(ovf));
	arith_checker arith_checker_i (.pclk(pclk), .presetn(presetn),
		.sfr_addr(sfr_if_i.sfr_addr), .sfr_wr(sfr_if_i.sfr_wr),
		.sfr_rd(sfr_if_i.sfr_rd), .sfr_wdata(sfr_if_i.sfr_wdata),
		.sfr_rdata(sfr_if_i.sfr_rdata), .calc_busy(busy),
		.calc_done_flag(done), .calc_error_flag(err),
		.arith_overflow_flag(ovf));

	// Clock, 10 ns period
	always #5 pclk = ~pclk;

	task automatic test_done();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic hang();
		errors++;
		test_done();
	endtask : hang

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, want);
		end
	endtask : chk

	task automatic flag(input logic got, input logic want);
		chk({31'h0, got}, {31'h0, want});
	endtask : flag

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] wd, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) hang();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One register bus access through the host, then poll until done
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] v);
		logic [31:0] r;
		logic e;
		int n;
		apb(1'b1, APB_CMD, {15'h0, w, a, v}, r, e);
		for (n = 0; n < 20; n++) begin
			apb(1'b0, APB_STATUS, 32'h0, r, e);
			if (r[0] === 1'b0) break;
		end
		if (n == 20) hang();
	endtask : sfr

	task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic en);
		exp_rd.push_back({en, v});
		sfr(1'b0, a, 8'h00);
	endtask : rd

	task automatic idle();
		int n;
		for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge pclk);
		if (n == 100) hang();
	endtask : idle

	// Load operands in the order that picks the operation, then read back
	task automatic run(input op_t op, input logic [31:0] a, input logic [15:0] b,
			input logic [7:0] ctl, input logic sgn, input logic poke);
		logic [31:0] res, x;
		logic signed [31:0] sp;
		logic [15:0] rem;
		logic v;
		int cyc, lz;
		rem = b;
		res = a;
		v = 1'b0;
		lz = ctl[4:0];
		sfr(1'b1, ADDR_MODE, {6'h00, sgn, 1'b0});
		sfr(1'b1, ADDR_OP0, a[7:0]);
		if (op == OP_MUL) begin
			sp = $signed(a[15:0]) * $signed(b);
			res = sgn ? a[15:0] * b : sp;
			v = sgn ? res > 32'h0000FFFF : (sp > 32767 || sp < -32768);
			sfr(1'b1, ADDR_OP4, b[7:0]);
			sfr(1'b1, ADDR_OP1, a[15:8]);
			exp_len.push_back(11);
			sfr(1'b1, ADDR_OP5, b[15:8]);
		end else if (op == OP_SHIFT) begin
			if (lz != 0) begin
				res = ctl[5] ? a >> lz : a << lz;
				cyc = 2 + (lz + 1) / 2;
			end else begin
				v = a[31];
				while (!res[31] && lz < 31) begin
					res = res << 1;
					lz++;
				end
				cyc = lz < 2 ? 4 : 3 + (lz + 1) / 2;
			end
			sfr(1'b1, ADDR_OP1, a[15:8]);
			sfr(1'b1, ADDR_OP2, a[23:16]);
			sfr(1'b1, ADDR_OP3, a[31:24]);
			exp_len.push_back(cyc);
			sfr(1'b1, ADDR_CTRL, ctl);
		end else begin
			x = op == OP_DIV16 ? {{16{a[15] & !sgn}}, a[15:0]} : a;
			if (b == 16'h0000)
				v = 1'b1;
			else if (sgn) begin
				res = x / b;
				sp = x % b;
				rem = sp[15:0];
			end else begin
				sp = $signed(x) / $signed(b);
				res = sp;
				sp = $signed(x) % $signed(b);
				rem = sp[15:0];
			end
			sfr(1'b1, ADDR_OP1, a[15:8]);
			if (op == OP_DIV32) begin
				sfr(1'b1, ADDR_OP2, a[23:16]);
				sfr(1'b1, ADDR_OP3, a[31:24]);
			end
			sfr(1'b1, ADDR_OP4, b[7:0]);
			exp_len.push_back(op == OP_DIV16 ? 9 : 17);
			sfr(1'b1, ADDR_OP5, b[15:8]);
		end
		if (poke) rd(ADDR_OP2, 8'h00, 1'b0);
		idle();
		flag(done, 1'b1);
		flag(ovf, v);
		flag(err, poke);
		rd(ADDR_CTRL, {poke, v, ctl[5], lz[4:0]}, op == OP_SHIFT);
		flag(err, 1'b0);
		rd(ADDR_OP0, res[7:0], 1'b1);
		rd(ADDR_OP1, res[15:8], 1'b1);
		if (op != OP_DIV16) begin
			rd(ADDR_OP2, res[23:16], 1'b1);
			rd(ADDR_OP3, res[31:24], 1'b1);
		end
		if (op == OP_DIV32 || op == OP_DIV16) begin
			rd(ADDR_OP4, rem[7:0], 1'b1);
			rd(ADDR_OP5, rem[15:8], 1'b1);
		end
	endtask : run

	// Monitor: read data one cycle after each strobe, and run lengths
	always @(negedge pclk) begin
		logic [8:0] x;
		if (rd_seen === 1'b1 && exp_rd.size() > 0) begin
			x = exp_rd.pop_front();
			st_x = x;
			if (x[8]) chk({24'h0, sfr_if_i.sfr_rdata},
				{24'h0, x[7:0]});
		end
		// The same byte must reach software once the host reports idle
		if (st_x[8] === 1'b1 && psel && penable && !pwrite
				&& paddr == APB_STATUS && prdata[0] === 1'b0) begin
			chk({24'h0, prdata[15:8]}, {24'h0, st_x[7:0]});
			st_x[8] = 1'b0;
		end
		rd_seen = sfr_if_i.sfr_rd;
		if (busy === 1'b1)
			run_len++;
		else if (run_len > 0) begin
			if (exp_len.size() > 0) chk(run_len, exp_len.pop_front());
			run_len = 0;
		end
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		logic e;
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, rd_seen} = 4'h0;
		st_x = 9'h000;
		paddr = 12'h000;
		pwdata = 32'h0;
		{errors, checked, run_len, seed} = {32'd0, 32'd0, 32'd0, 32'd39};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 8; i++) rd(regs[i], i == 0 ? 8'h10 : 8'h00, 1'b1);
		rd(8'hB0, NONE_READ, 1'b1);
		apb(1'b0, 12'h008, 32'h0, r, e);
		flag(e, 1'b1);
		run(OP_MUL, 32'h0000FFFF, 16'hFFFF, 8'h00, 1'b1, 1'b0);
		run(OP_MUL, 32'h00000064, 16'hFF9C, 8'h00, 1'b0, 1'b0);
		run(OP_DIV32, 32'hFFFFFF9C, 16'h0007, 8'h00, 1'b0, 1'b1);
		run(OP_DIV16, 32'h0000FFFF, 16'h0010, 8'h00, 1'b1, 1'b0);
		run(OP_SHIFT, 32'h80000001, 16'h0, 8'h01, 1'b1, 1'b0);
		run(OP_SHIFT, 32'h80000001, 16'h0, 8'h3F, 1'b1, 1'b0);
		run(OP_SHIFT, 32'h40000000, 16'h0, 8'h00, 1'b1, 1'b0);
		run(OP_SHIFT, 32'h80000000, 16'h0, 8'h00, 1'b1, 1'b0);
		run(OP_SHIFT, 32'h00000000, 16'h0, 8'h00, 1'b1, 1'b0);
		for (i = 0; i < 24; i++) begin
			c = $random(seed);
			d = $random(seed);
			run(ops[c[17:16]], d >> c[12:8], c[31:16],
				{2'b00, c[5], c[6] ? c[4:0] : 5'h00}, c[7], 1'b0);
		end
		run(OP_DIV32, 32'h12345678, 16'h0000, 8'h00, 1'b1, 1'b0);
		sfr(1'b1, ADDR_OP0, 8'h00);
		sfr(1'b1, ADDR_CTRL, 8'h00);
		sfr(1'b1, ADDR_MODE, 8'h00);
		flag(ovf, 1'b1);
		flag(done, 1'b1);
		rd(ADDR_CTRL, 8'h40, 1'b1);
		for (i = 1; i < 8; i++) begin
			sfr(1'b1, ADDR_OP0, 8'h12);
			sfr(1'b1, ADDR_OP4, 8'h34);
			sfr(1'b1, ADDR_OP1, 8'h56);
			sfr(1'b1, ADDR_OP5, 8'h78);
			sfr(1'b1, regs[i], 8'h01);
			idle();
			flag(err, 1'b1);
			rd(ADDR_CTRL, 8'h00, 1'b0);
			flag(err, 1'b0);
		end
		test_done();
	end
endmodule : mul_div_shift_unit_tb
`default_nettype wire

/* File: hw/arith_coprocessor.sv */
// Arithmetic coprocessor: divide, multiply, shift and normalise on six
// operand byte registers, reached over the special function register bus.
// Assumes single-cycle write/read strobes and one clock, pclk.
//
// Chosen here: the APB slave port.
`default_nettype none
module arith_coprocessor
	import arith_pkg::*;
(
	input  wire logic pclk,                // Clock
	input  wire logic presetn,             // Async reset, active low
	sfr_if.dev        bus,                 // Register bus
	output logic      calc_busy,           // Calculation executing
	output logic      calc_done_flag,      // Finish flag
	output logic      calc_error_flag,     // Error flag
	output logic      arith_overflow_flag  // Overflow flag
);
	logic [7:0] op_q [6];
	logic       sign_select_bit;
	logic       shift_direction_bit;
	logic [4:0] shift_count_field;
	logic       armed;
	logic [4:0] count;
	seq_t       seq, next_seq;
	op_t        run_op, start_op;
	op_t        last_op;
	logic       start;
	logic [4:0] start_cycles;

	// Index of an operand byte address; bit 3 marks a hit
	function automatic logic [3:0] op_index(input logic [7:0] a);
		if (a == ADDR_OP0) op_index = 4'h8;
		else if (a == ADDR_OP1) op_index = 4'h9;
		else if (a == ADDR_OP2) op_index = 4'hA;
		else if (a == ADDR_OP3) op_index = 4'hB;
		else if (a == ADDR_OP4) op_index = 4'hC;
		else if (a == ADDR_OP5) op_index = 4'hD;
		else op_index = 4'h0;
	endfunction : op_index

	// Leading zeros of a word, at most 31
	function automatic logic [4:0] lead_zeros(input logic [31:0] v);
		lead_zeros = 5'h1F;
		for (int i = 0; i < 31; i++) begin
			if (v[i]) lead_zeros = 5'(30 - i + 1);
		end
		for (int i = 31; i >= 0; i--) begin
			if (v[i] && (5'(31 - i) < lead_zeros)) lead_zeros = 5'(31 - i);
		end
	endfunction : lead_zeros

	// Half the count, rounded up
	function automatic logic [4:0] half_up(input logic [4:0] n);
		half_up = 5'((6'(n) + 6'h01) >> 1);
	endfunction : half_up

	// Bus decode
	wire [3:0] idx_hit = op_index(bus.sfr_addr);
	wire [2:0] idx     = idx_hit[2:0];
	wire wr_op   = bus.sfr_wr && idx_hit[3];
	wire rd_op   = bus.sfr_rd && idx_hit[3];
	wire wr_ctrl = bus.sfr_wr && (bus.sfr_addr == ADDR_CTRL);
	wire rd_ctrl = bus.sfr_rd && (bus.sfr_addr == ADDR_CTRL);
	wire wr_mode = bus.sfr_wr && (bus.sfr_addr == ADDR_MODE);
	wire wr_b0   = wr_op && (idx == 3'd0);
	wire [4:0] wr_sc = bus.sfr_wdata[SC_MSB:0];

	// Operand or control write during execution interrupts it; completion otherwise
	wire intrude = calc_busy && (wr_op || wr_ctrl);
	wire finish  = calc_busy && !intrude && (count == 5'h01);
	wire is_div  = (last_op == OP_DIV32) || (last_op == OP_DIV16);
	wire final_rd = rd_op && !calc_busy
		&& (idx == (is_div ? 3'd5 : 3'd3));

	// Operands as words, extended by sign select
	wire [31:0] val32 = {op_q[3], op_q[2], op_q[1], op_q[0]};
	wire [15:0] div16 = {op_q[5], op_q[4]};
	wire        ext   = !sign_select_bit;
	wire signed [32:0] dvd32 = {ext & val32[31], val32};
	wire signed [32:0] dvd16 = {{17{ext & val32[15]}}, val32[15:0]};
	wire signed [32:0] dvs   = {{17{ext & div16[15]}}, div16};
	wire signed [32:0] dvd   = (run_op == OP_DIV32) ? dvd32 : dvd16;
	wire        div_zero = (div16 == 16'h0000);
	wire signed [32:0] quot  = div_zero ? 33'sd0 : dvd / dvs;
	wire signed [32:0] rem   = div_zero ? 33'sd0 : dvd % dvs;
	wire signed [16:0] mul_a = {ext & op_q[1][7], op_q[1], op_q[0]};
	wire signed [16:0] mul_b = {ext & op_q[5][7], op_q[5], op_q[4]};
	wire signed [33:0] prod  = mul_a * mul_b;
	// Product overflow: does not fit 16 bits of the chosen kind
	wire mul_ovf = ext ? (prod[33:15] != {19{prod[15]}})
		: (prod[33:16] != 18'h00000);
	wire [4:0]  lz     = lead_zeros(val32);
	wire [31:0] shl    = val32 << shift_count_field;
	wire [31:0] shr    = val32 >> shift_count_field;
	wire [31:0] normed = val32 << lz;

	// Result words and overflow for the running operation
	logic [31:0] res_lo;
	logic [15:0] res_hi;
	logic        res_ovf;
	always_comb begin
		res_lo  = val32;
		res_hi  = div16;
		res_ovf = 1'b0;
		case (run_op)
			OP_DIV32, OP_DIV16: begin
				res_lo  = div_zero ? val32 : quot[31:0];
				res_hi  = div_zero ? div16 : rem[15:0];
				res_ovf = div_zero;
			end
			OP_MUL: begin
				res_lo  = prod[31:0];
				res_ovf = mul_ovf;
			end
			OP_SHIFT: res_lo = shift_direction_bit ? shr : shl;
			OP_NORM: begin
				res_lo  = normed;
				res_ovf = val32[31];
			end
			default: res_lo = val32;
		endcase
	end

	// Operation chosen by the order of writes; last write starts it
	always_comb begin
		next_seq = seq;
		start    = 1'b0;
		start_op = OP_MUL;
		if (wr_b0) begin
			next_seq = SEQ_B0;
		end else if (wr_op || wr_ctrl) begin
			next_seq = SEQ_IDLE;
			case (seq)
				SEQ_B0: begin
					if (wr_op && idx == 3'd1) next_seq = SEQ_B01;
					else if (wr_op && idx == 3'd4) next_seq = SEQ_B04;
				end
				SEQ_B01: begin
					if (wr_op && idx == 3'd2) next_seq = SEQ_B012;
					else if (wr_op && idx == 3'd4) next_seq = SEQ_B014;
				end
				SEQ_B012: begin
					if (wr_op && idx == 3'd3) next_seq = SEQ_B0123;
				end
				SEQ_B0123: begin
					if (wr_op && idx == 3'd4) begin
						next_seq = SEQ_B0124;
					end else if (wr_ctrl) begin
						start    = 1'b1;
						start_op = (wr_sc == 5'h00) ? OP_NORM
							: OP_SHIFT;
					end
				end
				SEQ_B04: begin
					if (wr_op && idx == 3'd1) next_seq = SEQ_B041;
				end
				SEQ_B041: begin
					start    = wr_op && idx == 3'd5;
					start_op = OP_MUL;
				end
				SEQ_B014: begin
					start    = wr_op && idx == 3'd5;
					start_op = OP_DIV16;
				end
				SEQ_B0124: begin
					start    = wr_op && idx == 3'd5;
					start_op = OP_DIV32;
				end
				default: next_seq = SEQ_IDLE;
			endcase
		end
	end

	// Run length of the operation being started
	always_comb begin
		case (start_op)
			OP_DIV32: start_cycles = DIV32_CYCLES;
			OP_DIV16: start_cycles = DIV16_CYCLES;
			OP_MUL:   start_cycles = MUL_CYCLES;
			OP_SHIFT: start_cycles = SHIFT_BASE + half_up(wr_sc);
			OP_NORM:  start_cycles = NORM_BASE
				+ ((lz == 5'h00) ? 5'h01 : half_up(lz));
			default:  start_cycles = MUL_CYCLES;
		endcase
	end

	// Operand bytes: bus writes, then results at completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 6; i++) op_q[i] <= OP_RESET;
		end else if (wr_op) begin
			op_q[idx] <= bus.sfr_wdata;
		end else if (finish) begin
			{op_q[3], op_q[2], op_q[1], op_q[0]} <= res_lo;
			{op_q[5], op_q[4]} <= res_hi;
		end
	end

	// Mode and control fields; error and overflow not writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sign_select_bit     <= 1'b0;
			shift_direction_bit <= 1'b0;
			shift_count_field   <= 5'h00;
		end else begin
			if (wr_mode) sign_select_bit <= bus.sfr_wdata[SIGN_BIT];
			if (wr_ctrl) begin
				shift_direction_bit <= bus.sfr_wdata[DIR_BIT];
				shift_count_field   <= wr_sc;
			end else if (finish && run_op == OP_NORM) begin
				shift_count_field <= lz;
			end
		end
	end

	// Sequencing runs beside the CPU; only the bus touches it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq            <= SEQ_IDLE;
			calc_busy      <= 1'b0;
			count          <= 5'h00;
			run_op         <= OP_MUL;
			last_op        <= OP_MUL;
			calc_done_flag <= DONE_RESET;
		end else begin
			seq <= next_seq;
			if (start) begin
				calc_busy      <= 1'b1;
				count          <= start_cycles;
				run_op         <= start_op;
				last_op        <= start_op;
				calc_done_flag <= 1'b0;
			end else if (intrude) begin
				calc_busy <= 1'b0;
			end else if (finish) begin
				calc_busy      <= 1'b0;
				calc_done_flag <= 1'b1;
			end else if (calc_busy) begin
				count <= count - 5'h01;
			end
		end
	end

	// Error flag: set wins over the clearing control read
	wire err_set = intrude
		|| (calc_busy && armed && rd_op);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calc_error_flag     <= 1'b0;
			arith_overflow_flag <= 1'b0;
			armed               <= 1'b0;
		end else begin
			calc_error_flag <= err_set
				|| (calc_error_flag && !rd_ctrl);
			if (finish) arith_overflow_flag <= res_ovf;
			if (wr_b0) armed <= 1'b1;
			else if (final_rd) armed <= 1'b0;
		end
	end

	// Registered read data; unmapped addresses read zero
	wire [7:0] mode_rd = {3'b000, calc_done_flag, 2'b00,
		sign_select_bit, 1'b0};
	wire [7:0] ctrl_rd = {calc_error_flag, arith_overflow_flag,
		shift_direction_bit, shift_count_field};
	wire [7:0] rd_val = rd_op ? op_q[idx]
		: rd_ctrl ? ctrl_rd
		: (bus.sfr_addr == ADDR_MODE) ? mode_rd : NONE_READ;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.sfr_rdata <= NONE_READ;
		end else if (bus.sfr_rd) begin
			bus.sfr_rdata <= rd_val;
		end
	end
endmodule : arith_coprocessor
`default_nettype wire

/* File: hw/arith_host.sv */
// CPU-side end: takes register accesses from APB and plays them onto the
// special function bus in the order software gives them.
// Assumes software issues operand writes and result reads in legal order.
`default_nettype none
module arith_host
	import arith_pkg::*;
(
	input  wire logic        pclk,    // Clock
	input  wire logic        presetn, // Async reset, active low
	input  wire logic [11:0] paddr,   // APB address
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB direction
	input  wire logic [31:0] pwdata,  // APB write data
	output logic [31:0]      prdata,  // APB read data
	output logic             pready,  // APB ready, always high
	output logic             pslverr, // Unmapped address
	sfr_if.cpu               bus      // Register bus
);
	logic       eng_ready;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic [7:0] last_read;

	// APB decode
	wire access    = psel && penable;
	wire hit_cmd   = (paddr == APB_CMD);
	wire hit_stat  = (paddr == APB_STATUS);
	// A command is forwarded at once; one arriving while busy is dropped
	wire launch    = access && pwrite && hit_cmd && eng_ready;
	// Busy stays up until the captured byte has reached last_read
	wire [31:0] status_word = {16'h0000, last_read, 7'h00,
		!eng_ready || rsp_valid};
	wire st_setup  = psel && !penable && !pwrite && hit_stat;

	assign pready  = 1'b1;
	assign pslverr = access && !hit_cmd && !hit_stat;

	// Accesses leave in APB order, so byte order is software's
	sfr_access_engine u_engine (
		.pclk      (pclk),
		.presetn   (presetn),
		.req_valid (launch),
		.req_ready (eng_ready),
		.req_write (pwdata[CMD_WRITE_BIT]),
		.req_addr  (pwdata[CMD_ADDR_LSB +: 8]),
		.req_wdata (pwdata[7:0]),
		.rsp_valid (rsp_valid),
		.rsp_data  (rsp_data),
		.bus       (bus)
	);

	// Keep the latest result byte for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_read <= OP_RESET;
		end else if (rsp_valid) begin
			last_read <= rsp_data;
		end
	end

	// Status taken in the setup cycle stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= st_setup ? status_word : 32'h0000_0000;
		end
	end
endmodule : arith_host
`default_nettype wire

/* File: hw/arith_pkg.sv */
// Shared constants and types of the arithmetic coprocessor and its host.
// Assumes one clock (pclk) and an 8-bit special function register bus.
`default_nettype none
package arith_pkg;
	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_MODE = 8'hAC;
	localparam logic [7:0] ADDR_CTRL = 8'hAD;
	localparam logic [7:0] ADDR_OP0  = 8'hAE;
	localparam logic [7:0] ADDR_OP1  = 8'hAF;
	localparam logic [7:0] ADDR_OP2  = 8'hB1;
	localparam logic [7:0] ADDR_OP3  = 8'hB2;
	localparam logic [7:0] ADDR_OP4  = 8'hB3;
	localparam logic [7:0] ADDR_OP5  = 8'hBA;
	// Reset values
	localparam logic       DONE_RESET = 1'b1;
	localparam logic [7:0] OP_RESET   = 8'h00;
	localparam logic [7:0] NONE_READ  = 8'h00;
	// Field positions
	localparam int DONE_BIT = 4;
	localparam int SIGN_BIT = 1;
	localparam int ERR_BIT  = 7;
	localparam int OVF_BIT  = 6;
	localparam int DIR_BIT  = 5;
	localparam int SC_MSB   = 4;
	// Execution times in clock cycles
	localparam logic [4:0] DIV32_CYCLES = 5'h11;
	localparam logic [4:0] DIV16_CYCLES = 5'h09;
	localparam logic [4:0] MUL_CYCLES   = 5'h0B;
	localparam logic [4:0] SHIFT_BASE   = 5'h02;
	localparam logic [4:0] NORM_BASE    = 5'h03;
	// Host register map (APB byte addresses) and command fields
	localparam logic [11:0] APB_CMD    = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam int CMD_WRITE_BIT = 16;
	localparam int CMD_ADDR_LSB  = 8;
	localparam int STAT_DATA_LSB = 8;

	// Progress through the operand write sequence
	typedef enum logic [3:0] {
		SEQ_IDLE  = 4'b0000,
		SEQ_B0    = 4'b0001,
		SEQ_B01   = 4'b0010,
		SEQ_B012  = 4'b0011,
		SEQ_B0123 = 4'b0100,
		SEQ_B04   = 4'b0101,
		SEQ_B041  = 4'b0110,
		SEQ_B014  = 4'b0111,
		SEQ_B0124 = 4'b1000
	} seq_t;

	typedef enum logic [2:0] {
		OP_DIV32 = 3'b000,
		OP_DIV16 = 3'b001,
		OP_MUL   = 3'b010,
		OP_SHIFT = 3'b011,
		OP_NORM  = 3'b100
	} op_t;

	typedef enum logic [1:0] {
		ENG_IDLE  = 2'b00,
		ENG_ISSUE = 2'b01,
		ENG_CAPT  = 2'b10
	} eng_t;
endpackage : arith_pkg
`default_nettype wire

/* File: hw/sfr_access_engine.sv */
// Performs one register access at a time on the special function bus.
// Assumes the device answers a read on the cycle after the read strobe.
`default_nettype none
module sfr_access_engine
	import arith_pkg::*;
(
	input  wire logic       pclk,      // Clock
	input  wire logic       presetn,   // Async reset, active low
	input  wire logic       req_valid, // Access request
	output logic            req_ready, // Engine idle
	input  wire logic       req_write, // 1 write, 0 read
	input  wire logic [7:0] req_addr,  // Register address
	input  wire logic [7:0] req_wdata, // Write data
	output logic            rsp_valid, // Read data captured
	output logic [7:0]      rsp_data,  // Captured read data
	sfr_if.cpu              bus        // Register bus
);
	eng_t state;
	logic is_write;

	assign req_ready = (state == ENG_IDLE);

	// Issue one strobe per request, collect read data a cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state         <= ENG_IDLE;
			is_write      <= 1'b0;
			bus.sfr_addr  <= OP_RESET;
			bus.sfr_wdata <= OP_RESET;
			bus.sfr_wr    <= 1'b0;
			bus.sfr_rd    <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp_data      <= OP_RESET;
		end else begin
			rsp_valid <= 1'b0;
			case (state)
				ENG_IDLE: begin
					if (req_valid) begin
						bus.sfr_addr  <= req_addr;
						bus.sfr_wdata <= req_wdata;
						bus.sfr_wr    <= req_write;
						bus.sfr_rd    <= !req_write;
						is_write      <= req_write;
						state         <= ENG_ISSUE;
					end
				end
				ENG_ISSUE: begin
					bus.sfr_wr <= 1'b0;
					bus.sfr_rd <= 1'b0;
					state      <= is_write ? ENG_IDLE : ENG_CAPT;
				end
				ENG_CAPT: begin
					rsp_data  <= bus.sfr_rdata;
					rsp_valid <= 1'b1;
					state     <= ENG_IDLE;
				end
				default: state <= ENG_IDLE;
			endcase
		end
	end
endmodule : sfr_access_engine
`default_nettype wire

/* File: hw/sfr_if.sv */
// Special function register bus between a CPU-side host and the coprocessor.
// Strobes are one-cycle pulses; read data returns one cycle after sfr_rd.
`default_nettype none
interface sfr_if;
	logic [7:0] sfr_addr;  // Register address
	logic       sfr_wr;    // Write strobe
	logic       sfr_rd;    // Read strobe
	logic [7:0] sfr_wdata; // Write data
	logic [7:0] sfr_rdata; // Read data, registered in the device

	modport cpu (output sfr_addr, sfr_wr, sfr_rd, sfr_wdata,
		input sfr_rdata);
	modport dev (input sfr_addr, sfr_wr, sfr_rd, sfr_wdata,
		output sfr_rdata);
endinterface : sfr_if
`default_nettype wire
